// *** pkg/nfc_pkg.sv ***
// Package for the NAND erase/ID/status/reset host controller
// Notes on behaviour
// - At most one block per district per erase.
// - Erase setup 60+addr, 60+addr, then D0.
// - End setup with D0, or abandon with FF.
// - After 70h status byte on each read.
// - While busy only 70h, 71h, FFh allowed.
`default_nettype none
package nfc_pkg;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] NFC_CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] NFC_CMD_ERASE_START = 8'hD0;
   localparam logic [7:0] NFC_CMD_READ_ID     = 8'h90;
   localparam logic [7:0] NFC_CMD_STATUS      = 8'h70;
   localparam logic [7:0] NFC_CMD_STATUS_DIST = 8'h71;
   localparam logic [7:0] NFC_CMD_RESET       = 8'hFF;
   localparam logic [7:0] NFC_ID_ADDR         = 8'h00;
   // ----------------------------------------------------------------
   // Software register map (word index = addr)
   // ----------------------------------------------------------------
   localparam logic [3:0] NFC_REG_CTRL   = 4'h0;
   localparam logic [3:0] NFC_REG_BLK0   = 4'h1;
   localparam logic [3:0] NFC_REG_BLK1   = 4'h2;
   localparam logic [3:0] NFC_REG_STATUS = 4'h3;
   localparam logic [3:0] NFC_REG_RESULT = 4'h4;
   localparam logic [3:0] NFC_REG_ID_LO  = 4'h5;
   localparam logic [3:0] NFC_REG_ID_HI  = 4'h6;
   // CTRL write: op code in bits 2:0
   localparam logic [2:0] NFC_OP_ERASE1 = 3'h1;
   localparam logic [2:0] NFC_OP_ERASE2 = 3'h2;
   localparam logic [2:0] NFC_OP_ID     = 3'h3;
   localparam logic [2:0] NFC_OP_STATUS = 3'h4;
   localparam logic [2:0] NFC_OP_STDIST = 3'h5;
   localparam logic [2:0] NFC_OP_RESET  = 3'h6;
   // Status byte fields
   localparam int NFC_ST_PF1   = 0;
   localparam int NFC_ST_PF2   = 1;
   localparam int NFC_ST_PBRDY = 5;
   localparam int NFC_ST_DCRDY = 6;
   localparam int NFC_ST_NOWP  = 7;
   // Geometry
   localparam int NFC_ROW_BYTES   = 3;
   localparam int NFC_PAGE_BITS   = 6;
   localparam int NFC_BLK_BITS    = 12;
   localparam int NFC_ID_BYTES    = 5;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int NFC_CLK_PS      = 5000;
   localparam int NFC_STROBE_PS   = 25000;
   localparam int NFC_STROBE_CYC  = (NFC_STROBE_PS + NFC_CLK_PS - 1) / NFC_CLK_PS;
   localparam int NFC_WB_PS       = 100000;
   localparam int NFC_WB_CYC      = (NFC_WB_PS + NFC_CLK_PS - 1) / NFC_CLK_PS;
   localparam logic [7:0] NFC_STROBE_W = 8'(NFC_STROBE_CYC);
   localparam logic [7:0] NFC_WB_W     = 8'(NFC_WB_CYC);
endpackage
`default_nettype wire

// *** src/nfc_host.sv ***
// Host controller driving a NAND device for erase, ID, status and reset
`default_nettype none
module nfc_host
   import nfc_pkg::*;
(
   // Clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   // Software port
   input  wire logic [3:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic     [31:0] o_rdata,
   // Flash pins
   output logic            o_ce_n,
   output logic            o_cle,
   output logic            o_ale,
   output logic            o_we_n,
   output logic            o_read_strobe_n,
   output logic            o_wp_n,
   output logic     [7:0]  o_io,
   output logic            o_io_oe_n,
   input  wire logic [7:0] i_io,
   input  wire logic       i_ready_busy_pin
);
   typedef enum logic [3:0] {
      NFC_IDLE, NFC_CMD, NFC_ADDR, NFC_WAITB, NFC_POLL, NFC_RCMD, NFC_RDATA, NFC_NEXT
   } nfc_state_t;

   typedef struct packed {
      nfc_state_t  st;
      logic [2:0]  op;
      logic [1:0]  phase;
      logic [7:0]  cnt;
      logic [2:0]  idx;
      logic [NFC_BLK_BITS-1:0] blk0;
      logic [NFC_BLK_BITS-1:0] blk1;
      logic [7:0]  cur_cmd;
      logic [7:0]  status;
      logic [39:0] id;
      logic        busy;
      logic        err;
      logic        wp_n;
      logic [31:0] rdata;
      logic        ce_n, cle, ale, we_n, re_n, oe_n;
      logic [7:0]  io;
      logic        rst_pend;
   } nfc_regs_t;

   nfc_regs_t r, nxt;
   logic [23:0] row;
   logic        rst_req;
   logic        at_gap;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt = r;
      // Row address of the block chosen for this erase pass
      row = {{(24-NFC_BLK_BITS-NFC_PAGE_BITS){1'b0}},
             (r.phase == 2'd0) ? r.blk0 : r.blk1, {NFC_PAGE_BITS{1'b0}}};
      if (i_wr && i_addr == NFC_REG_BLK0) nxt.blk0 = i_wdata[NFC_BLK_BITS-1:0];
      if (i_wr && i_addr == NFC_REG_BLK1) nxt.blk1 = i_wdata[NFC_BLK_BITS-1:0];
      if (i_wr && i_addr == NFC_REG_CTRL) nxt.wp_n = i_wdata[8];
      // Each bus cycle: strobe low for NFC_STROBE_CYC clocks, then high for NFC_STROBE_CYC+1 clocks more
      unique case (r.st)
         NFC_IDLE: ;
         NFC_CMD, NFC_ADDR: begin
            nxt.ce_n = 1'b0; nxt.oe_n = 1'b0; nxt.re_n = 1'b1;
            nxt.cle = (r.st == NFC_CMD); nxt.ale = (r.st == NFC_ADDR);
            nxt.io = (r.st == NFC_CMD) ? r.cur_cmd
                   : (r.op == NFC_OP_ID) ? NFC_ID_ADDR : row[8*r.idx +: 8];
            nxt.cnt = r.cnt + 8'h01;
            nxt.we_n = (r.cnt < NFC_STROBE_W) ? 1'b0 : 1'b1;
            if (r.cnt == 8'(2*NFC_STROBE_CYC)) begin
               nxt.cnt = 8'h00; nxt.we_n = 1'b1; nxt.cle = 1'b0; nxt.ale = 1'b0;
               nxt.st = NFC_NEXT;
            end
         end
         NFC_NEXT: begin
            nxt.st = NFC_IDLE;
            unique case (r.op)
               NFC_OP_ERASE1, NFC_OP_ERASE2: begin
                  if (r.cur_cmd == NFC_CMD_ERASE_SETUP) begin
                     nxt.st = NFC_ADDR; nxt.idx = 3'h0; nxt.cur_cmd = 8'h00;
                  end else if (r.cur_cmd == 8'h00) begin
                     if (r.idx == 3'(NFC_ROW_BYTES-1)) begin
                        nxt.st = NFC_CMD;
                        // Second setup for the other district, else start
                        if (r.op == NFC_OP_ERASE2 && r.phase == 2'd0) begin
                           nxt.phase = 2'd1; nxt.cur_cmd = NFC_CMD_ERASE_SETUP;
                        end else begin
                           nxt.cur_cmd = NFC_CMD_ERASE_START;
                        end
                     end else begin
                        nxt.idx = r.idx + 3'h1; nxt.st = NFC_ADDR;
                     end
                  end else begin
                     nxt.st = NFC_WAITB; nxt.cnt = 8'h00;
                  end
               end
               NFC_OP_ID: begin
                  if (r.cur_cmd == NFC_CMD_READ_ID) begin
                     nxt.cur_cmd = 8'h00; nxt.st = NFC_ADDR; nxt.idx = 3'h0;
                  end else begin
                     nxt.st = NFC_RDATA; nxt.idx = 3'h0; nxt.oe_n = 1'b1;
                  end
               end
               NFC_OP_RESET: begin
                  nxt.st = NFC_WAITB; nxt.cnt = 8'h00;
               end
               default: begin
                  nxt.st = NFC_RDATA; nxt.oe_n = 1'b1; nxt.idx = 3'h0;
               end
            endcase
         end
         NFC_WAITB: begin
            // Give the device time to drop its busy pin
            nxt.cnt = r.cnt + 8'h01;
            if (r.cnt >= NFC_WB_W) nxt.st = NFC_POLL;
         end
         NFC_POLL: begin
            if (i_ready_busy_pin) begin
               // Fetch status to report pass or fail
               nxt.op = NFC_OP_STATUS; nxt.cur_cmd = NFC_CMD_STATUS;
               nxt.st = NFC_CMD; nxt.cnt = 8'h00;
            end
         end
         NFC_RDATA: begin
            nxt.oe_n = 1'b1; nxt.ce_n = 1'b0;
            nxt.cnt = r.cnt + 8'h01;
            nxt.re_n = (r.cnt < NFC_STROBE_W) ? 1'b0 : 1'b1;
            if (r.cnt == NFC_STROBE_W - 8'h01) begin
               if (r.op == NFC_OP_ID) nxt.id[8*r.idx +: 8] = i_io;
               else nxt.status = i_io;
            end
            if (r.cnt == 8'(2*NFC_STROBE_CYC)) begin
               nxt.cnt = 8'h00; nxt.re_n = 1'b1;
               if (r.op == NFC_OP_ID && r.idx != 3'(NFC_ID_BYTES-1)) begin
                  nxt.idx = r.idx + 3'h1;
               end else begin
                  nxt.st = NFC_IDLE; nxt.busy = 1'b0; nxt.ce_n = 1'b1;
               end
            end
         end
         default: nxt.st = NFC_IDLE;
      endcase

      // Software orders come after the bus cycle logic so that they win
      // Reset is always accepted, even mid-setup or while busy
      // It waits for a strobe gap so that no strobe pulse is cut short
      rst_req = r.rst_pend || (i_wr && i_addr == NFC_REG_CTRL && i_wdata[2:0] == NFC_OP_RESET);
      at_gap  = !(r.st inside {NFC_CMD, NFC_ADDR, NFC_RDATA}) || (r.cnt == 8'(2*NFC_STROBE_CYC));
      if (rst_req && at_gap) begin
         nxt.op = NFC_OP_RESET;
         nxt.cur_cmd = NFC_CMD_RESET;
         nxt.phase = 2'd0;
         nxt.st = NFC_CMD;
         nxt.cnt = 8'h00;
         nxt.busy = 1'b1;
         nxt.err = 1'b0;
         nxt.rst_pend = 1'b0;
      end else if (rst_req) begin
         nxt.rst_pend = 1'b1;
      end else if (i_wr && i_addr == NFC_REG_CTRL && !r.busy && i_wdata[2:0] != 3'h0) begin
         nxt.op = i_wdata[2:0]; nxt.phase = 2'd0; nxt.cnt = 8'h00; nxt.idx = 3'h0;
         nxt.busy = 1'b1; nxt.st = NFC_CMD; nxt.err = 1'b0;
         // Two blocks must sit in different districts (low bit)
         if (i_wdata[2:0] == NFC_OP_ERASE2 && r.blk0[0] == r.blk1[0]) begin
            nxt.err = 1'b1; nxt.busy = 1'b0; nxt.st = NFC_IDLE;
         end
         unique case (i_wdata[2:0])
            NFC_OP_ERASE1, NFC_OP_ERASE2: nxt.cur_cmd = NFC_CMD_ERASE_SETUP;
            NFC_OP_ID:     nxt.cur_cmd = NFC_CMD_READ_ID;
            NFC_OP_STDIST: nxt.cur_cmd = NFC_CMD_STATUS_DIST;
            default:       nxt.cur_cmd = NFC_CMD_STATUS;
         endcase
      end else if (i_wr && i_addr == NFC_REG_CTRL && r.busy) begin
         nxt.err = 1'b1;
      end

      // Read port
      nxt.rdata = 32'h0000_0000;
      if (i_rd) begin
         unique case (i_addr)
            NFC_REG_CTRL:   nxt.rdata = {23'h0, r.wp_n, 5'h0, r.op};
            NFC_REG_BLK0:   nxt.rdata = {20'h0, r.blk0};
            NFC_REG_BLK1:   nxt.rdata = {20'h0, r.blk1};
            // Status byte with error, ready pin and busy flags
            NFC_REG_STATUS: nxt.rdata = {21'h0, r.err, i_ready_busy_pin, r.busy, r.status};
            NFC_REG_RESULT: nxt.rdata = {29'h0,
                                         r.status[NFC_ST_PBRDY] & r.status[NFC_ST_PF1],
                                         r.status[NFC_ST_DCRDY] & r.status[NFC_ST_PF2],
                                         r.status[NFC_ST_NOWP]};
            NFC_REG_ID_LO:  nxt.rdata = r.id[31:0];
            NFC_REG_ID_HI:  nxt.rdata = {24'h0, r.id[39:32]};
            default:        nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         r       <= '0;
         r.st    <= NFC_IDLE;
         r.ce_n  <= 1'b1;
         r.we_n  <= 1'b1;
         r.re_n  <= 1'b1;
         r.oe_n  <= 1'b1;
         r.wp_n  <= 1'b0;
      end else begin
         r <= nxt;
      end
   end

   assign o_rdata         = r.rdata;
   assign o_ce_n          = r.ce_n;
   assign o_cle           = r.cle;
   assign o_ale           = r.ale;
   assign o_we_n          = r.we_n;
   assign o_read_strobe_n = r.re_n;
   assign o_wp_n          = r.wp_n;
   assign o_io            = r.io;
   assign o_io_oe_n       = r.oe_n;
endmodule
`default_nettype wire

// *** sim/nfc_host_props.sv ***
// Checker on the host controller pins and software port
`default_nettype none
module nfc_host_props
   import nfc_pkg::*;
(
   // Clock, reset and software writes
   input wire logic        i_mclk, i_rst, i_wr,
   input wire logic [3:0]  i_addr,
   input wire logic [31:0] i_wdata,
   // Flash pins
   input wire logic        o_ce_n, o_cle, o_ale, o_we_n, o_read_strobe_n, o_io_oe_n, i_ready_busy_pin,
   input wire logic [7:0]  o_io
);
   timeunit 1ns / 100ps;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   property p_latch; !(o_cle && o_ale); endproperty
   a_latch: assert property (p_latch) else $error("cle and ale high together");
   property p_strobes; o_we_n || o_read_strobe_n; endproperty
   a_strobes: assert property (p_strobes) else $error("both strobes low");
   property p_cmd; o_cle && !o_we_n |-> !o_io_oe_n && !o_ce_n; endproperty
   a_cmd: assert property (p_cmd) else $error("command byte not driven");
   property p_we; $fell(o_we_n) |=> !o_we_n [*4] ##1 o_we_n; endproperty
   a_we: assert property (p_we) else $error("write strobe width");
   property p_re; $fell(o_read_strobe_n) |-> o_io_oe_n && !o_ce_n ##1 !o_read_strobe_n [*4] ##1 o_read_strobe_n; endproperty
   a_re: assert property (p_re) else $error("read strobe shape");
   property p_busy; $rose(o_we_n) && o_cle && !$past(i_ready_busy_pin) |-> o_io inside {8'h70, 8'h71, 8'hFF}; endproperty
   a_busy: assert property (p_busy) else $error("command while busy");
   property p_rst; i_wr && i_addr == NFC_REG_CTRL && i_wdata[2:0] == NFC_OP_RESET |-> ##[1:60] (o_cle && !o_we_n && o_io == 8'hFF); endproperty
   a_rst: assert property (p_rst) else $error("reset command not sent");
   property p_id; $rose(o_we_n) && o_cle && o_io == 8'h90 |-> ##[1:20] ($rose(o_we_n) && o_ale && o_io == 8'h00); endproperty
   a_id: assert property (p_id) else $error("id address missing");
endmodule
`default_nettype wire

// *** sim/nfc_dev_model.sv ***
// Behavioural flash device for erase, ID, status and reset
`default_nettype none
module nfc_dev_model
   import nfc_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE  = 8'h11, // Arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'h22  // Arbitrary value
)(
   // Strobes and data from the host
   input  wire logic        i_ce_n, i_cle, i_ale, i_we_n, i_re_n, i_wp_n,
   input  wire logic [7:0]  i_io,
   // Busy time and erase outcome
   input  wire logic [15:0] i_busy_ns,
   input  wire logic        i_fail,
   // Answers; ready level includes the pull-up
   output logic      [7:0]  o_io,
   output logic             o_rb,
   output logic      [11:0] o_blk_a, o_blk_b,
   output logic      [7:0]  o_erases
);
   timeunit 1ns / 100ps;
   logic [7:0]  cmd = 8'h00, idx = 8'h00, acnt = 8'h00, nblk = 8'h00;
   logic [23:0] row = 24'h0;
   logic        fail_r = 1'b0;
   logic [39:0] id;
   assign id = {8'h76, 8'h26, 8'h91, DEVICE_CODE, MAKER_CODE};
   initial begin
      o_rb = 1'b1;
      o_io = 8'h00;
      o_erases = 8'h00;
   end
   always @(posedge i_we_n) begin
      if (!i_ce_n && i_cle) begin
         cmd = i_io;
         idx = 8'h00;
         acnt = 8'h00;
         if (cmd == NFC_CMD_ERASE_START || cmd == NFC_CMD_RESET) begin
            o_erases = o_erases + {7'h0, cmd == NFC_CMD_ERASE_START};
            fail_r = i_fail;
            nblk = 8'h00;
            o_rb = 1'b0;
            o_rb <= #(cmd == NFC_CMD_RESET ? 16'h0064 : i_busy_ns) 1'b1;
         end
      end else if (!i_ce_n && i_ale && cmd == NFC_CMD_ERASE_SETUP) begin
         row = {i_io, row[23:8]};
         acnt = acnt + 8'h01;
         if (acnt == 8'h03) begin
            nblk = nblk + 8'h01;
            if (nblk == 8'h01) o_blk_a = row[17:6];
            else o_blk_b = row[17:6];
         end
      end
   end
   always @(negedge i_re_n) begin
      if (!i_ce_n && cmd == NFC_CMD_READ_ID) o_io = id[8*idx +: 8];
      else if (!i_ce_n && cmd == NFC_CMD_STATUS) o_io = {i_wp_n, o_rb, o_rb, 4'h0, fail_r & o_rb};
      else if (!i_ce_n) o_io = {i_wp_n, o_rb, o_rb, 2'b00, {3{fail_r & o_rb}}};
   end
   // Released bus shows the inverse, never the last value
   always @(posedge i_re_n) begin
      o_io = ~o_io;
      idx = idx + 8'h01;
   end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the flash host controller
`default_nettype none
module testbench;
   timeunit 1ns / 100ps;
   import nfc_pkg::*;
   localparam logic [7:0] MAKER = 8'hA5;   // Arbitrary value
   localparam logic [7:0] DEVCODE = 8'h3C; // Arbitrary value
   logic        i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, fail = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [15:0] busy_ns = 16'h0032;
   int          num_errors = 0, cmp_count = 0, ne = 0;
   wire logic        ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb;
   wire logic [7:0]  io_h, io_d, bus, erases;
   wire logic [11:0] blk_a, blk_b;
   wire logic [31:0] rdata;
   assign bus = !oe_n ? io_h : io_d;
   always #2.5 i_mclk = ~i_mclk;
   nfc_host dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(rdata), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(re_n),
      .o_wp_n(wp_n), .o_io(io_h), .o_io_oe_n(oe_n), .i_io(bus), .i_ready_busy_pin(rb));
   nfc_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVCODE)) u_dev (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale),
      .i_we_n(we_n), .i_re_n(re_n), .i_wp_n(wp_n), .i_io(bus), .i_busy_ns(busy_ns), .i_fail(fail),
      .o_io(io_d), .o_rb(rb), .o_blk_a(blk_a), .o_blk_b(blk_b), .o_erases(erases));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      d = rdata;
      @(posedge i_mclk);
   endtask
   task automatic op(input logic [2:0] c, input logic wp);
      logic [31:0] s;
      wreg(NFC_REG_CTRL, {23'h0, wp, 5'h0, c});
      s = 32'h100;
      for (int n = 0; n < 3000 && s[8] !== 1'b0; n++) rreg(NFC_REG_STATUS, s);
   endtask
   task automatic t_id;
      logic [31:0] d;
      op(NFC_OP_ID, 1'b1);
      rreg(NFC_REG_ID_LO, d);
      chk(d, {8'h26, 8'h91, DEVCODE, MAKER});
      rreg(NFC_REG_ID_HI, d);
      chk({24'h0, d[7:0]}, 32'h76);
   endtask
   task automatic t_status;
      logic [31:0] d;
      for (int w = 0; w < 2; w++) begin
         op(NFC_OP_STATUS, w[0]);
         rreg(NFC_REG_STATUS, d);
         chk({24'h0, d[7:0]}, {24'h0, w[0], 7'h60});
      end
   endtask
   task automatic t_erase(input logic [11:0] b0, input logic [11:0] b1, input logic [15:0] t, input logic f);
      logic [31:0] d;
      busy_ns <= t;
      fail <= f;
      ne++;
      wreg(NFC_REG_BLK0, {20'h0, b0});
      wreg(NFC_REG_BLK1, {20'h0, b1});
      op(NFC_OP_ERASE2, 1'b1);
      chk({blk_a, blk_b, erases}, {b0, b1, 8'(ne)});
      rreg(NFC_REG_RESULT, d);
      chk({29'h0, d[2:0]}, {29'h0, f, 2'b01});
      op(NFC_OP_STDIST, 1'b1);
      rreg(NFC_REG_STATUS, d);
      chk({24'h0, d[7:0]}, {24'h0, 5'h1C, {3{f}}});
   endtask
   task automatic t_reset;
      logic [31:0] d;
      realtime t0;
      busy_ns <= 16'h07D0;
      fail <= 1'b0;
      ne++;
      wreg(NFC_REG_BLK0, 32'h5);
      wreg(NFC_REG_CTRL, {23'h0, 1'b1, 5'h0, NFC_OP_ERASE1});
      t0 = $realtime;
      for (int n = 0; n < 300 && rb !== 1'b0; n++) @(posedge i_mclk);
      op(NFC_OP_RESET, 1'b1);
      chk({31'h0, ($realtime - t0) < 1500.0}, 32'h1);
      wreg(NFC_REG_CTRL, {23'h0, 1'b1, 5'h0, NFC_OP_RESET});
      op(NFC_OP_RESET, 1'b1);
      rreg(NFC_REG_STATUS, d);
      chk({24'h0, d[7:0]}, 32'hE0);
   endtask
   task automatic t_refuse;
      logic [31:0] d;
      wreg(NFC_REG_BLK0, 32'h2);
      wreg(NFC_REG_BLK1, 32'h4);
      op(NFC_OP_ERASE2, 1'b1);
      rreg(NFC_REG_STATUS, d);
      chk({23'h0, d[10], erases}, {23'h0, 1'b1, 8'(ne)});
   endtask
   task automatic final_report;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge i_mclk);
      i_rst <= 1'b0;
      t_id();
      t_status();
      t_erase(12'h801, 12'hFFE, 16'h0032, 1'b0);
      t_erase(12'h7FE, 12'h003, 16'h0190, 1'b0);
      t_erase(12'h800, 12'h801, 16'h0032, 1'b1);
      t_reset();
      t_refuse();
      final_report();
   end
   initial begin
      #60us;
      num_errors++;
      final_report();
   end
endmodule
bind nfc_host nfc_host_props u_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(i_wr), .i_addr(i_addr),
   .i_wdata(i_wdata), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
   .o_read_strobe_n(o_read_strobe_n), .o_io_oe_n(o_io_oe_n), .i_ready_busy_pin(i_ready_busy_pin), .o_io(o_io));
`default_nettype wire
